// file: core/eag_pkg.sv
package eag_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int EAG_RAW_W  = 24;
   localparam int EAG_BUS_W  = 16;
   localparam int EAG_REG_W  = 32;
   localparam int EAG_BIT_W  = 3;

   // ----------------------------------------------------------------
   // Address forming constants
   // ----------------------------------------------------------------
   localparam logic [15:0] EAG_SHORT_ABS_FILL = 16'hffff;
   localparam logic [15:0] EAG_MEMIND_FILL    = 16'h0000;
   localparam logic [7:0]  EAG_DISP24_FILL    = 8'h00;
   localparam logic [23:0] EAG_TRAP_VEC_BASE  = 24'h000010;
   localparam int          EAG_TRAP_VEC_SHIFT = 2;
   localparam logic [31:0] EAG_STEP_B         = 32'h00000001;
   localparam logic [31:0] EAG_STEP_W         = 32'h00000002;
   localparam logic [31:0] EAG_STEP_L         = 32'h00000004;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EAG_M_REG_DIRECT = 3'h0,
      EAG_M_REG_IND    = 3'h1,
      EAG_M_REG_DISP   = 3'h2,
      EAG_M_REG_STEP   = 3'h3,
      EAG_M_ABSOLUTE   = 3'h4,
      EAG_M_IMMEDIATE  = 3'h5,
      EAG_M_PC_REL     = 3'h6,
      EAG_M_MEM_IND    = 3'h7
   } eag_mode_t;

   typedef enum logic [2:0] {
      EAG_C_ALU    = 3'h0,
      EAG_C_XFER   = 3'h1,
      EAG_C_BIT    = 3'h2,
      EAG_C_JUMP   = 3'h3,
      EAG_C_BRREL  = 3'h4,
      EAG_C_TRAP   = 3'h5,
      EAG_C_IMPLIC = 3'h6
   } eag_class_t;

   typedef enum logic [1:0] {
      EAG_SZ_BYTE = 2'h0,
      EAG_SZ_WORD = 2'h1,
      EAG_SZ_LONG = 2'h2
   } eag_size_t;

   // Length of the extension field: abs 8/16/24, disp 16/24,
   // pc-relative 8/16, immediate 8/16/32
   typedef enum logic [1:0] {
      EAG_L_SHORT = 2'h0,
      EAG_L_MID   = 2'h1,
      EAG_L_LONG  = 2'h2
   } eag_len_t;

   typedef enum logic [2:0] {
      EAG_ST_IDLE = 3'b001,
      EAG_ST_PTR  = 3'b010,
      EAG_ST_DONE = 3'b100
   } eag_state_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      eag_class_t  cls;
      eag_mode_t   mode;
      eag_size_t   size;
      eag_len_t    len;
      logic        dec;
      logic        bit_from_reg;
      logic [3:0]  reg_fld;
      logic [31:0] ext;
      logic [31:0] address_register;
      logic [31:0] general_register;
      logic [23:0] pc;
   } eag_req_t;

   typedef struct packed {
      logic        illegal;
      logic [15:0] ea;
      logic [31:0] operand;
      logic [3:0]  reg_idx;
      logic [2:0]  bit_num;
      logic        wb_en;
      logic [31:0] wb_val;
   } eag_rsp_t;

endpackage

// file: core/eag_effective_address_generator.sv
// Overview of operation
// - Form a 24-bit address, drop top eight bits, 16 bits reach memory
// - Exactly eight addressing modes are supported
// - Arithmetic/logic instructions take only register direct or immediate
// - Data transfers take all modes but pc-relative and memory indirect
// - Bit ops: direct, indirect or absolute; bit number from imm or reg
// - Register indirect uses low 24 bits of the address register
// - Displacement 16 (sign-extended) or 24 bits added, low 24 used
// - Post-increment: low 24 address, then register plus 1/2/4 written
// - Pre-decrement: register minus 1/2/4 written back, low 24 address
// - Short absolute fills upper bits with ones: FF00 to FFFF
// - 16-bit absolute sign-extended, 24-bit unchanged: full range
// - Immediate from 8/16/32-bit field; constant ops imply their value
// - Software trap 2-bit field selects the exception vector
// - PC relative: sign-extended 8/16-bit displacement plus 24-bit pc
// - Branch reach -126..+128 or -32766..+32768; target not forced even
// - Memory indirect: pointer at 0000..00FF, fetched by longword read
// - Pointer's first byte dropped, three bytes form the target
`timescale 1ns/10ps
`default_nettype none

module eag_effective_address_generator
   import eag_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   // Decoder request
   input  wire logic        req_valid_in,
   input  wire eag_req_t    req_in,
   output logic             req_ready_out,
   // Result
   output logic             rsp_valid_out,
   output eag_rsp_t         rsp_out,
   // Pointer read on the memory bus
   output logic             rd_req_out,
   output logic [15:0]      rd_addr_out,
   input  wire logic        rd_ack_in,
   input  wire logic [31:0] rd_data_in
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   eag_state_t  state_ff,   nxt_state;
   eag_req_t    req_ff,     nxt_req;
   eag_rsp_t    rsp_ff,     nxt_rsp;
   logic [23:0] raw_ff,     nxt_raw;
   logic        rd_req_ff,  nxt_rd_req;
   logic [15:0] rd_addr_ff, nxt_rd_addr;

   // ----------------------------------------------------------------
   // Address arithmetic
   // ----------------------------------------------------------------
   logic [31:0] step;
   logic [31:0] stepped;
   logic [23:0] raw;
   logic        legal;
   logic [31:0] operand;
   logic [2:0]  bit_num;

   always_comb
   begin
      case (req_in.size)
         EAG_SZ_BYTE: step = EAG_STEP_B;
         EAG_SZ_WORD: step = EAG_STEP_W;
         default:     step = EAG_STEP_L;
      endcase
      // Odd registers step as given; keeping them even is software's job
      if (req_in.dec)
         stepped = req_in.address_register - step;
      else
         stepped = req_in.address_register + step;
   end

   always_comb
   begin
      raw = 24'h000000;
      case (req_in.mode)
         EAG_M_REG_IND:
            raw = req_in.address_register[23:0];
         EAG_M_REG_DISP:
            if (req_in.len == EAG_L_LONG)
               raw = 24'(req_in.address_register
                         + {EAG_DISP24_FILL, req_in.ext[23:0]});
            else
               raw = 24'(req_in.address_register
                         + {{16{req_in.ext[15]}}, req_in.ext[15:0]});
         EAG_M_REG_STEP:
            if (req_in.dec)
               raw = stepped[23:0];
            else
               raw = req_in.address_register[23:0];
         EAG_M_ABSOLUTE:
            case (req_in.len)
               EAG_L_SHORT:
                  raw = {EAG_SHORT_ABS_FILL, req_in.ext[7:0]};
               EAG_L_MID:
                  raw = {{8{req_in.ext[15]}}, req_in.ext[15:0]};
               default:
                  raw = req_in.ext[23:0];
            endcase
         EAG_M_PC_REL:
            // Pc already points past the branch, giving the lopsided reach
            if (req_in.len == EAG_L_SHORT)
               raw = req_in.pc + {{16{req_in.ext[7]}}, req_in.ext[7:0]};
            else
               raw = req_in.pc + {{8{req_in.ext[15]}}, req_in.ext[15:0]};
         EAG_M_MEM_IND:
            raw = {EAG_MEMIND_FILL, req_in.ext[7:0]};
         default:
            raw = 24'h000000;
      endcase
      if (req_in.cls == EAG_C_TRAP)
         raw = EAG_TRAP_VEC_BASE
               + (24'(req_in.ext[1:0]) << EAG_TRAP_VEC_SHIFT);
   end

   // ----------------------------------------------------------------
   // Mode legality per instruction class
   // ----------------------------------------------------------------
   always_comb
   begin
      case (req_in.cls)
         EAG_C_ALU:
            legal = (req_in.mode == EAG_M_REG_DIRECT)
                    || (req_in.mode == EAG_M_IMMEDIATE);
         EAG_C_XFER:
            legal = (req_in.mode != EAG_M_PC_REL)
                    && (req_in.mode != EAG_M_MEM_IND);
         EAG_C_BIT:
            legal = (req_in.mode == EAG_M_REG_DIRECT)
                    || (req_in.mode == EAG_M_REG_IND)
                    || (req_in.mode == EAG_M_ABSOLUTE);
         EAG_C_JUMP:
            legal = (req_in.mode == EAG_M_REG_IND)
                    || (req_in.mode == EAG_M_ABSOLUTE)
                    || (req_in.mode == EAG_M_MEM_IND);
         EAG_C_BRREL:
            legal = (req_in.mode == EAG_M_PC_REL);
         EAG_C_TRAP, EAG_C_IMPLIC:
            legal = (req_in.mode == EAG_M_IMMEDIATE);
         default:
            legal = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Operand, register select and bit number
   // ----------------------------------------------------------------
   always_comb
   begin
      operand = 32'h00000000;
      if (req_in.cls == EAG_C_IMPLIC)
         operand = step;
      else if (req_in.mode == EAG_M_IMMEDIATE)
         case (req_in.len)
            EAG_L_SHORT: operand = {24'h000000, req_in.ext[7:0]};
            EAG_L_MID:   operand = {16'h0000, req_in.ext[15:0]};
            default:     operand = req_in.ext;
         endcase
      if (req_in.bit_from_reg)
         bit_num = req_in.general_register[2:0];
      else
         bit_num = req_in.ext[2:0];
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_state   = state_ff;
      nxt_req     = req_ff;
      nxt_rsp     = rsp_ff;
      nxt_raw     = raw_ff;
      nxt_rd_req  = 1'b0;
      nxt_rd_addr = rd_addr_ff;
      case (state_ff)
         EAG_ST_IDLE:
            if (req_valid_in)
            begin
               nxt_req             = req_in;
               nxt_raw             = raw;
               nxt_rsp.illegal     = !legal;
               nxt_rsp.ea          = raw[15:0];
               nxt_rsp.operand     = operand;
               nxt_rsp.bit_num     = bit_num;
               // Long registers only have eight names
               nxt_rsp.reg_idx     = (req_in.size == EAG_SZ_LONG)
                                     ? {1'b0, req_in.reg_fld[2:0]}
                                     : req_in.reg_fld;
               nxt_rsp.wb_en       = legal
                                     && (req_in.mode == EAG_M_REG_STEP);
               nxt_rsp.wb_val      = stepped;
               if (legal && (req_in.mode == EAG_M_MEM_IND))
               begin
                  nxt_rd_req  = 1'b1;
                  nxt_rd_addr = raw[15:0];
                  nxt_state   = EAG_ST_PTR;
               end
               else
                  nxt_state = EAG_ST_DONE;
            end
         EAG_ST_PTR:
         begin
            nxt_rd_req = !rd_ack_in;
            if (rd_ack_in)
            begin
               nxt_raw    = rd_data_in[23:0];
               nxt_rsp.ea = rd_data_in[15:0];
               nxt_state  = EAG_ST_DONE;
            end
         end
         EAG_ST_DONE:
            nxt_state = EAG_ST_IDLE;
         default:
            nxt_state = EAG_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_ff   <= EAG_ST_IDLE;
         req_ff     <= '0;
         rsp_ff     <= '0;
         raw_ff     <= 24'h000000;
         rd_req_ff  <= 1'b0;
         rd_addr_ff <= 16'h0000;
      end
      else
      begin
         state_ff   <= nxt_state;
         req_ff     <= nxt_req;
         rsp_ff     <= nxt_rsp;
         raw_ff     <= nxt_raw;
         rd_req_ff  <= nxt_rd_req;
         rd_addr_ff <= nxt_rd_addr;
      end
   end

   assign req_ready_out = (state_ff == EAG_ST_IDLE);
   assign rsp_valid_out = (state_ff == EAG_ST_DONE);
   assign rsp_out       = rsp_ff;
   assign rd_req_out    = rd_req_ff;
   assign rd_addr_out   = rd_addr_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   logic take;
   assign take = req_valid_in && req_ready_out;

   // Long displacement carries into bits the bus never sees
   property p_trunc;
      take && req_in.mode == EAG_M_REG_DISP && req_in.len == EAG_L_LONG
      && req_in.cls == EAG_C_XFER
      |=> rsp_out.ea == 16'(req_ff.address_register[15:0]
                            + req_ff.ext[15:0]);
   endproperty
   a_trunc: assert property (p_trunc)
      else $error("Address not low 16 bits of raw address");

   property p_alu_modes;
      take && req_in.cls == EAG_C_ALU
      && req_in.mode != EAG_M_REG_DIRECT
      && req_in.mode != EAG_M_IMMEDIATE
      |=> rsp_valid_out && rsp_out.illegal;
   endproperty
   a_alu_modes: assert property (p_alu_modes)
      else $error("Alu mode not refused");

   property p_xfer_modes;
      take && req_in.cls == EAG_C_XFER
      |=> rsp_out.illegal == (req_ff.mode inside
                              {EAG_M_PC_REL, EAG_M_MEM_IND});
   endproperty
   a_xfer_modes: assert property (p_xfer_modes)
      else $error("Transfer legality wrong");

   property p_reg_ind;
      take && req_in.mode == EAG_M_REG_IND && req_in.cls != EAG_C_TRAP
      |=> rsp_out.ea == req_ff.address_register[15:0];
   endproperty
   a_reg_ind: assert property (p_reg_ind)
      else $error("Indirect address wrong");

   property p_post_inc;
      take && req_in.mode == EAG_M_REG_STEP && !req_in.dec
      && req_in.size == EAG_SZ_LONG && req_in.cls == EAG_C_XFER
      |=> rsp_out.wb_en
          && rsp_out.wb_val == req_ff.address_register + 32'h00000004
          && rsp_out.ea == req_ff.address_register[15:0];
   endproperty
   a_post_inc: assert property (p_post_inc)
      else $error("Post-increment wrong");

   property p_pre_dec;
      take && req_in.mode == EAG_M_REG_STEP && req_in.dec
      && req_in.size == EAG_SZ_WORD && req_in.cls == EAG_C_XFER
      |=> rsp_out.wb_val == req_ff.address_register - 32'h00000002
          && rsp_out.ea == rsp_out.wb_val[15:0];
   endproperty
   a_pre_dec: assert property (p_pre_dec)
      else $error("Pre-decrement wrong");

   property p_short_abs;
      take && req_in.mode == EAG_M_ABSOLUTE
      && req_in.len == EAG_L_SHORT && req_in.cls != EAG_C_TRAP
      |=> rsp_out.ea[15:8] == 8'hff;
   endproperty
   a_short_abs: assert property (p_short_abs)
      else $error("Short absolute not in top page");

   property p_pc_rel;
      take && req_in.mode == EAG_M_PC_REL && req_in.len == EAG_L_SHORT
      && req_in.cls == EAG_C_BRREL
      |=> rsp_out.ea == 16'(req_ff.pc[15:0]
                      + {{8{req_ff.ext[7]}}, req_ff.ext[7:0]});
   endproperty
   a_pc_rel: assert property (p_pc_rel)
      else $error("Pc-relative target wrong");

   property p_ptr_read;
      take && req_in.mode == EAG_M_MEM_IND && req_in.cls == EAG_C_JUMP
      |=> rd_req_out && rd_addr_out[15:8] == 8'h00 && !rsp_valid_out;
   endproperty
   a_ptr_read: assert property (p_ptr_read)
      else $error("Pointer read not issued in low page");

   property p_ptr_use;
      rd_req_out && rd_ack_in
      |=> rsp_valid_out && rsp_out.ea == $past(rd_data_in[15:0]);
   endproperty
   a_ptr_use: assert property (p_ptr_use)
      else $error("Pointer target not used");

   c_post_inc: cover property (take && req_in.mode == EAG_M_REG_STEP);
   c_mem_ind:  cover property (rd_req_out ##1 rsp_valid_out);
   c_illegal:  cover property (rsp_valid_out && rsp_out.illegal);
   c_pc_rel:   cover property (take && req_in.mode == EAG_M_PC_REL);

endmodule // eag_effective_address_generator

`default_nettype wire

// file: verif/eag_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module eag_mem_model
   import eag_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   // Pointer read from the generator
   input  wire logic        rd_req_in,
   input  wire logic [15:0] rd_addr_in,
   input  wire logic [3:0]  wait_cyc_in,
   output logic             rd_ack_out,
   output logic [31:0]      rd_data_out
);

   // ----
   // Memory responder
   // ----
   logic        ack_ff = 1'b0;
   logic [3:0]  cnt_ff = 4'h0;
   logic [31:0] dat_ff = 32'h0;

   // Falling edge: the generator samples settled values on the rise.
   // Data flips every cycle outside the ack so stale data never matches.
   always @(negedge mclk_in)
   begin
      ack_ff <= 1'b0;
      dat_ff <= ~dat_ff;
      if (!rst_n_in || !rd_req_in || ack_ff)
         cnt_ff <= 4'h0;
      else if (cnt_ff == wait_cyc_in)
      begin
         ack_ff <= 1'b1;
         dat_ff <= {8'hc3, 8'h5a ^ rd_addr_in[7:0],
                    rd_addr_in[7:0], 8'h3c};
         cnt_ff <= 4'h0;
      end
      else
         cnt_ff <= cnt_ff + 4'h1;
   end

   assign rd_ack_out  = ack_ff;
   assign rd_data_out = dat_ff;

endmodule // eag_mem_model

`default_nettype wire

// file: verif/eag_effective_address_generator_test.sv
`timescale 1ns/10ps
`default_nettype none

module eag_effective_address_generator_test
   import eag_pkg::*;
;

   // ----
   // Signals
   // ----
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        req_valid = 1'b0;
   eag_req_t    req = '0;
   logic        req_ready;
   logic        rsp_valid;
   logic        rd_req;
   logic        rd_ack;
   eag_rsp_t    rsp;
   logic [15:0] rd_addr;
   logic [15:0] ptr_addr = 16'h0;
   logic [31:0] rd_data;
   logic [3:0]  wait_cyc = 4'h0;
   wire  [31:0] ea32;
   int          err_count = 0;
   int          cmp_count = 0;

   assign ea32 = {16'h0, rsp.ea};

   always #25 mclk = ~mclk;

   always @(negedge mclk)
      if (rd_req === 1'b1)
         ptr_addr <= rd_addr;

   eag_effective_address_generator dut_u (.mclk_in(mclk),
      .rst_n_in(rst_n), .req_valid_in(req_valid), .req_in(req),
      .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
      .rsp_out(rsp), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
      .rd_ack_in(rd_ack), .rd_data_in(rd_data));

   eag_mem_model mem_u (.mclk_in(mclk), .rst_n_in(rst_n),
      .rd_req_in(rd_req), .rd_addr_in(rd_addr), .wait_cyc_in(wait_cyc),
      .rd_ack_out(rd_ack), .rd_data_out(rd_data));

   // ----
   // Helpers
   // ----
   task automatic end_of_test();
      $display("Compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic eag_req_t mk(eag_class_t c, eag_mode_t m);
      eag_req_t r;
      r = '0;
      r.cls = c;
      r.mode = m;
      return r;
   endfunction

   // Waits for idle, offers one request, returns in the answer cycle
   task automatic issue(input eag_req_t r);
      for (int i = 0; i < 20 && req_ready !== 1'b1; i++)
         @(negedge mclk);
      if (req_ready !== 1'b1)
      begin
         err_count++;
         end_of_test();
      end
      req = r;
      req_valid = 1'b1;
      @(negedge mclk);
      req_valid = 1'b0;
      for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++)
         @(negedge mclk);
      if (rsp_valid !== 1'b1)
      begin
         err_count++;
         end_of_test();
      end
      chk({30'h0, req_ready, rd_req}, 32'h0);
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_abs();
      eag_req_t q;
      q = mk(EAG_C_XFER, EAG_M_ABSOLUTE);
      q.ext = 32'h0000_1234;
      issue(q);
      chk(ea32, 32'hff34);
      q.len = EAG_L_MID;
      q.ext = 32'h0000_8123;
      issue(q);
      chk(ea32, 32'h8123);
      q.len = EAG_L_LONG;
      q.ext = 32'h0012_abcd;
      issue(q);
      chk(ea32, 32'habcd);
   endtask

   task automatic t_ind();
      eag_req_t q;
      q = mk(EAG_C_XFER, EAG_M_REG_IND);
      q.address_register = 32'h7712_3456;
      issue(q);
      chk(ea32, 32'h3456);
      q.mode = EAG_M_REG_DISP;
      q.ext = 32'h0000_fff0;
      for (int l = 1; l < 3; l++)
      begin
         q.len = eag_len_t'(l[1:0]);
         issue(q);
         chk(ea32, 32'h3446);
      end
   endtask

   task automatic t_step();
      eag_req_t q;
      logic [31:0] st;
      q = mk(EAG_C_XFER, EAG_M_REG_STEP);
      for (int s = 0; s < 3; s++)
      begin
         st = 32'h1 << s;
         q.size = eag_size_t'(s[1:0]);
         q.dec = 1'b0;
         q.address_register = 32'h00ff_fffc;
         issue(q);
         chk(ea32, 32'hfffc);
         chk(rsp.wb_val, 32'h00ff_fffc + st);
         q.dec = 1'b1;
         q.address_register = 32'h0100_0000;
         issue(q);
         chk(ea32, {16'h0, 16'h0 - st[15:0]});
         chk(rsp.wb_val, 32'h0100_0000 - st);
         chk({31'h0, rsp.wb_en}, 32'h1);
      end
   endtask

   task automatic t_dir();
      eag_req_t q;
      q = mk(EAG_C_ALU, EAG_M_REG_DIRECT);
      q.reg_fld = 4'hb;
      issue(q);
      chk({28'h0, rsp.reg_idx}, 32'hb);
      q.size = EAG_SZ_LONG;
      issue(q);
      chk({28'h0, rsp.reg_idx}, 32'h3);
      q = mk(EAG_C_BIT, EAG_M_REG_DIRECT);
      q.ext = 32'h5;
      q.general_register = 32'h0000_00fa;
      issue(q);
      chk({29'h0, rsp.bit_num}, 32'h5);
      q.bit_from_reg = 1'b1;
      issue(q);
      chk({29'h0, rsp.bit_num}, 32'h2);
   endtask

   task automatic t_imm();
      eag_req_t q;
      logic [31:0] e [3] = '{32'hef, 32'hbeef, 32'hdeadbeef};
      for (int l = 0; l < 3; l++)
      begin
         q = mk(EAG_C_ALU, EAG_M_IMMEDIATE);
         q.ext = 32'hdeadbeef;
         q.len = eag_len_t'(l[1:0]);
         issue(q);
         chk(rsp.operand, e[l]);
         q.cls = EAG_C_IMPLIC;
         q.size = eag_size_t'(l[1:0]);
         issue(q);
         chk(rsp.operand, 32'h1 << l);
      end
   endtask

   task automatic t_trap();
      eag_req_t    q;
      logic [31:0] want;
      q = mk(EAG_C_TRAP, EAG_M_IMMEDIATE);
      for (int v = 0; v < 4; v++)
      begin
         q.ext = {30'h0, v[1:0]};
         want = {16'h0, EAG_TRAP_VEC_BASE[15:0]}
                + (32'(v) << EAG_TRAP_VEC_SHIFT);
         issue(q);
         chk(ea32, want);
      end
   endtask

   // Targets kept even: even counter plus even displacement
   task automatic t_rel();
      eag_req_t q;
      logic [15:0] x [4] = '{16'h0080, 16'h007e, 16'h8000, 16'h7ffe};
      logic [15:0] e [4] = '{16'h0f80, 16'h107e, 16'h9000, 16'h8ffe};
      q = mk(EAG_C_BRREL, EAG_M_PC_REL);
      q.pc = 24'h12_1000;
      for (int i = 0; i < 4; i++)
      begin
         q.len = (i < 2) ? EAG_L_SHORT : EAG_L_MID;
         q.ext = {16'h0, x[i]};
         issue(q);
         chk(ea32, {16'h0, e[i]});
      end
   endtask

   task automatic t_mind();
      eag_req_t q;
      q = mk(EAG_C_JUMP, EAG_M_MEM_IND);
      for (int w = 0; w < 2; w++)
      begin
         wait_cyc = (w == 0) ? 4'h0 : 4'h6;
         q.ext = (w == 0) ? 32'h0000_a540 : 32'h0000_a5c2;
         issue(q);
         chk({16'h0, ptr_addr}, {24'h0, q.ext[7:0]});
         chk(ea32, {16'h0, q.ext[7:0], 8'h3c});
      end
   endtask

   // Every class against every mode; a refused pair never writes back
   task automatic t_legal();
      eag_mode_t   m;
      logic        bad;
      logic        wb;
      logic [31:0] got;
      for (int c = 0; c < 7; c++)
         for (int k = 0; k < 8; k++)
         begin
            m = eag_mode_t'(k[2:0]);
            wb = (c == 1) && (m == EAG_M_REG_STEP);
            case (c)
               0: bad = !(m inside {EAG_M_REG_DIRECT, EAG_M_IMMEDIATE});
               1: bad = m inside {EAG_M_PC_REL, EAG_M_MEM_IND};
               2: bad = !(m inside {EAG_M_REG_DIRECT, EAG_M_REG_IND,
                                    EAG_M_ABSOLUTE});
               3: bad = !(m inside {EAG_M_REG_IND, EAG_M_ABSOLUTE,
                                    EAG_M_MEM_IND});
               4: bad = m != EAG_M_PC_REL;
               default: bad = m != EAG_M_IMMEDIATE;
            endcase
            issue(mk(eag_class_t'(c[2:0]), m));
            got = {30'h0, rsp.illegal, rsp.wb_en};
            chk(got, {30'h0, bad, wb});
         end
   endtask

   // ----
   // Main sequence
   // ----
   initial
   begin
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      t_abs();
      t_ind();
      t_step();
      t_dir();
      t_imm();
      t_trap();
      t_rel();
      t_mind();
      t_legal();
      end_of_test();
   end

endmodule // eag_effective_address_generator_test

`default_nettype wire
